// ### buzzer_regs.vh
// Purpose : Register map, field positions and timing for the buzzer tone generator
// Assumes : 32-bit APB data, one register per aligned word
// Notes   : Byte address of a register is four times its index
`ifndef BUZZER_REGS_VH
`define BUZZER_REGS_VH

// ------------------------------------------------------------
// Register indexes and byte addresses
// ------------------------------------------------------------
`define IDX_BURST_ENVELOPE_CONTROL 18'h0FF44
`define IDX_TONE_DUTY_FREQUENCY    18'h0FF45
`define ADDR_BURST_ENVELOPE_CONTROL (`IDX_BURST_ENVELOPE_CONTROL << 2)
`define ADDR_TONE_DUTY_FREQUENCY    (`IDX_TONE_DUTY_FREQUENCY << 2)

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BIT_TONE_OUTPUT_ENABLE 0
`define BIT_ENVELOPE_ENABLE    1
`define BIT_ENVELOPE_RESTART   2
`define BIT_ENVELOPE_TIME_SEL  3
`define BIT_BURST_LENGTH_SEL   4
`define BIT_BURST_TRIGGER      5
`define BIT_BURST_FORCE_STOP   6
`define FREQ_LSB 0
`define DUTY_LSB 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_FREQ 3'h0
`define RST_DUTY 3'h0
`define RST_BIT  1'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_HZ          25000000
`define CLK_PER_US      25
`define CLK_PER_MS      25000
`define SUBSTEP_HZ      65536
`define SUBSTEP_DIV     9'h17D
`define BURST_LONG_US   125000
`define BURST_SHORT_US  31250
`define ENV_LONG_MS     1000
`define ENV_SHORT_MS    500
`define ENV_STEPS       7
// Sized to the parameter widths; products of the counts above, the envelope ones divided by ENV_STEPS, rounded down
`define BURST_LONG_CYC  25'h02FAF08
`define BURST_SHORT_CYC 25'h00BEBC2
`define ENV_LONG_CYC    25'h0367EE4
`define ENV_SHORT_CYC   25'h01B3F72
`define PERIOD_LEN0     5'h10
`define PERIOD_LEN1     5'h14
`define PERIOD_LEN2     5'h18
`define PERIOD_LEN3     5'h1C
`define HIGH_BASE_NARROW 5'h08
`define HIGH_BASE_WIDE   5'h0C
`define DUTY_NARROWEST  3'h7

`endif

// ### buzzer_tone_envelope_generator.v
// Purpose : Buzzer tone generator with one-shot bursts and duty envelope
// Assumes : APB slave, one clock, inputs synchronous to sys_clk
// Notes   : No wait state on any access; unmapped addresses answer pslverr
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "buzzer_regs.vh"

// Overview of operation
// - Output tone while enabled or during a burst, reset off
// - Three-bit code picks one of eight frequencies
// - Duty code zero widest, each code narrower
// - Period 16/20/24/28 sub-steps, high 8/8/12/12, twice that on codes 4-7
// - Narrowest duty gives 1,1,5,5 sub-steps
// - Trigger write starts burst, reads busy
// - Burst length 125 ms or 31.25 ms
// - Force stop ends burst, returns ready
// - Envelope enable attenuates tone duty
// - Envelope time one or half second
// - Restart returns envelope to start, reads zero
// - Burst clears envelope enable while running
module buzzer_tone_envelope_generator
#(
   parameter        ADDR_W          = 18,
   parameter [8:0]  SUBSTEP_DIV     = `SUBSTEP_DIV,
   parameter [24:0] BURST_LONG_CYC  = `BURST_LONG_CYC,
   parameter [24:0] BURST_SHORT_CYC = `BURST_SHORT_CYC,
   parameter [24:0] ENV_LONG_CYC    = `ENV_LONG_CYC,
   parameter [24:0] ENV_SHORT_CYC   = `ENV_SHORT_CYC
)
(
   input  wire              sys_clk,
   input  wire              reset_n,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   output reg               buzzer_out
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg        tone_output_enable;
   reg        envelope_enable;
   reg        envelope_time_sel;
   reg        burst_length_sel;
   reg        burst_busy;
   reg [2:0]  tone_freq_sel;
   reg [2:0]  tone_duty_sel;
   reg [24:0] burst_cnt;
   reg [24:0] env_cnt;
   reg [2:0]  env_step;
   reg [8:0]  substep_cnt;
   reg        half_rate;
   reg [4:0]  phase;
   reg [4:0]  period_len;
   reg [4:0]  high_base;
   reg        slow_tone;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire sel_ctrl = (paddr == `ADDR_BURST_ENVELOPE_CONTROL);
   wire sel_tone = (paddr == `ADDR_TONE_DUTY_FREQUENCY);
   wire mapped   = sel_ctrl | sel_tone;
   wire wr_go    = psel & penable & pready & pwrite & mapped;
   wire wr_ctrl  = wr_go & sel_ctrl;
   wire wr_tone  = wr_go & sel_tone;

   wire trig_wr    = wr_ctrl & pwdata[`BIT_BURST_TRIGGER];
   wire stop_wr    = wr_ctrl & pwdata[`BIT_BURST_FORCE_STOP];
   wire restart_wr = wr_ctrl & pwdata[`BIT_ENVELOPE_RESTART];

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // Registered answer keeps every bus output straight from a flip-flop
   reg [31:0] next_rdata;

   always @*
   begin
      next_rdata = 32'h00000000;
      if (sel_ctrl)
      begin
         next_rdata[`BIT_TONE_OUTPUT_ENABLE] = tone_output_enable;
         next_rdata[`BIT_ENVELOPE_ENABLE]    = envelope_enable;
         next_rdata[`BIT_ENVELOPE_TIME_SEL]  = envelope_time_sel;
         next_rdata[`BIT_BURST_LENGTH_SEL]   = burst_length_sel;
         next_rdata[`BIT_BURST_TRIGGER]      = burst_busy;
      end
      else if (sel_tone)
      begin
         next_rdata[`FREQ_LSB+2:`FREQ_LSB] = tone_freq_sel;
         next_rdata[`DUTY_LSB+2:`DUTY_LSB] = tone_duty_sel;
      end
   end

   // ------------------------------------------------------------
   // APB answer
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
      else if (psel & ~penable)
      begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= pwrite ? 32'h00000000 : next_rdata;
      end
      else
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tone_output_enable <= `RST_BIT;
         envelope_time_sel  <= `RST_BIT;
         burst_length_sel   <= `RST_BIT;
         tone_freq_sel      <= `RST_FREQ;
         tone_duty_sel      <= `RST_DUTY;
      end
      else
      begin
         if (wr_ctrl)
         begin
            tone_output_enable <= pwdata[`BIT_TONE_OUTPUT_ENABLE];
            envelope_time_sel  <= pwdata[`BIT_ENVELOPE_TIME_SEL];
            burst_length_sel   <= pwdata[`BIT_BURST_LENGTH_SEL];
         end
         if (wr_tone)
         begin
            tone_freq_sel <= pwdata[`FREQ_LSB+2:`FREQ_LSB];
            tone_duty_sel <= pwdata[`DUTY_LSB+2:`DUTY_LSB];
         end
      end
   end

   // ------------------------------------------------------------
   // Envelope enable
   // ------------------------------------------------------------
   // Envelope enable is held clear for the whole burst
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         envelope_enable <= `RST_BIT;
      end
      else if (burst_busy | trig_wr & ~stop_wr)
      begin
         envelope_enable <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         envelope_enable <= pwdata[`BIT_ENVELOPE_ENABLE];
      end
   end

   // ------------------------------------------------------------
   // One-shot burst
   // ------------------------------------------------------------
   // Stop beats a trigger in the same write; a retrigger restarts the timer
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         burst_busy <= 1'b0;
         burst_cnt  <= 25'h0000000;
      end
      else if (stop_wr)
      begin
         burst_busy <= 1'b0;
         burst_cnt  <= 25'h0000000;
      end
      else if (trig_wr)
      begin
         burst_busy <= 1'b1;
         burst_cnt  <= pwdata[`BIT_BURST_LENGTH_SEL] ? BURST_LONG_CYC - 25'h0000001
                                                      : BURST_SHORT_CYC - 25'h0000001;
      end
      else if (burst_busy)
      begin
         if (burst_cnt == 25'h0000000)
         begin
            burst_busy <= 1'b0;
         end
         else
         begin
            burst_cnt <= burst_cnt - 25'h0000001;
         end
      end
   end

   // ------------------------------------------------------------
   // Envelope
   // ------------------------------------------------------------
   // Interval is fixed per step, so a wider start duty takes longer to fade
   wire [24:0] env_interval = envelope_time_sel ? ENV_LONG_CYC : ENV_SHORT_CYC;
   wire [3:0]  duty_sum     = {1'b0, tone_duty_sel} + {1'b0, env_step};
   wire        at_floor     = (duty_sum >= {1'b0, `DUTY_NARROWEST});
   wire [2:0]  eff_duty     = at_floor ? `DUTY_NARROWEST : duty_sum[2:0];

   // ------------------------------------------------------------
   // Envelope step
   // ------------------------------------------------------------
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         env_step <= 3'h0;
         env_cnt  <= 25'h0000000;
      end
      else if (restart_wr | ~envelope_enable)
      begin
         env_step <= 3'h0;
         env_cnt  <= 25'h0000000;
      end
      else if (!at_floor)
      begin
         if (env_cnt >= env_interval - 25'h0000001)
         begin
            env_cnt  <= 25'h0000000;
            env_step <= env_step + 3'h1;
         end
         else
         begin
            env_cnt <= env_cnt + 25'h0000001;
         end
      end
   end

   // ------------------------------------------------------------
   // Tone waveform
   // ------------------------------------------------------------
   // Sub-step rate is rounded from the clock; the pitch is off by a fraction
   wire substep_tick = (substep_cnt == SUBSTEP_DIV - 9'h001);
   wire tone_tick    = substep_tick & (~slow_tone | half_rate);
   wire [4:0] high_len   = high_base - {2'b00, eff_duty};
   wire       sounding   = tone_output_enable | burst_busy;

   // Period, widest high time and rate per code; a table keeps each code visible
   always @*
   begin
      case (tone_freq_sel)
         3'h0:
         begin
            period_len = `PERIOD_LEN0;
            high_base  = `HIGH_BASE_NARROW;
            slow_tone  = 1'b0;
         end
         3'h1:
         begin
            period_len = `PERIOD_LEN1;
            high_base  = `HIGH_BASE_NARROW;
            slow_tone  = 1'b0;
         end
         3'h2:
         begin
            period_len = `PERIOD_LEN2;
            high_base  = `HIGH_BASE_WIDE;
            slow_tone  = 1'b0;
         end
         3'h3:
         begin
            period_len = `PERIOD_LEN3;
            high_base  = `HIGH_BASE_WIDE;
            slow_tone  = 1'b0;
         end
         3'h4:
         begin
            period_len = `PERIOD_LEN0;
            high_base  = `HIGH_BASE_NARROW;
            slow_tone  = 1'b1;
         end
         3'h5:
         begin
            period_len = `PERIOD_LEN1;
            high_base  = `HIGH_BASE_NARROW;
            slow_tone  = 1'b1;
         end
         3'h6:
         begin
            period_len = `PERIOD_LEN2;
            high_base  = `HIGH_BASE_WIDE;
            slow_tone  = 1'b1;
         end
         3'h7:
         begin
            period_len = `PERIOD_LEN3;
            high_base  = `HIGH_BASE_WIDE;
            slow_tone  = 1'b1;
         end
         default:
         begin
            period_len = `PERIOD_LEN0;
            high_base  = `HIGH_BASE_NARROW;
            slow_tone  = 1'b0;
         end
      endcase
   end

   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         substep_cnt <= 9'h000;
         half_rate   <= 1'b0;
         phase       <= 5'h00;
         buzzer_out  <= 1'b0;
      end
      else
      begin
         substep_cnt <= substep_tick ? 9'h000 : substep_cnt + 9'h001;
         if (substep_tick)
         begin
            half_rate <= ~half_rate;
         end
         if (!sounding)
         begin
            phase <= 5'h00;
         end
         else if (tone_tick)
         begin
            phase <= (phase >= period_len - 5'h01) ? 5'h00 : phase + 5'h01;
         end
         buzzer_out <= sounding & (phase < high_len);
      end
   end

endmodule // buzzer_tone_envelope_generator

// ### buzzer_checker_asserts.sv
// Purpose : Port checker for the buzzer tone generator
// Assumes : Shadows follow accepted APB writes
// Notes   : Busy window trimmed by four cycles for margin
`timescale 1ns/1ps
`include "buzzer_regs.vh"
module buzzer_checker
#(
   parameter [8:0]  SUBSTEP_DIV     = 9'h004,
   parameter [24:0] BURST_SHORT_CYC = 25'h0000032
)
(
   input wire        sys_clk,
   input wire        reset_n,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [17:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        buzzer_out
);
   localparam int BT = BURST_SHORT_CYC - 4;
   localparam int HM = 24 * SUBSTEP_DIV;
   wire       acc = psel && penable && pready;
   wire       ac  = paddr == `ADDR_BURST_ENVELOPE_CONTROL;
   wire       at  = paddr == `ADDR_TONE_DUTY_FREQUENCY;
   wire       wc  = acc && pwrite && ac;
   wire       rc  = acc && !pwrite && ac;
   reg  [7:0] ctl;
   reg        bs;
   reg        q;
   reg [15:0] tc;
   reg [15:0] hc;
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctl <= 8'h00;
         bs  <= 1'b0;
         q   <= 1'b1;
         tc  <= 16'hFFFF;
         hc  <= 16'h0000;
      end
      else
      begin
         // Quiet one cycle late: output lags the enable and burst state by a cycle
         q  <= !ctl[0] && !bs;
         hc <= buzzer_out ? hc + 16'h0001 : 16'h0000;
         tc <= (wc && pwdata[5]) ? 16'h0000 : tc + {15'h0000, tc != 16'hFFFF};
         if (wc)
            ctl <= pwdata[7:0];
         if (wc && (pwdata[5] || pwdata[6]))
            bs <= !pwdata[6];
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   AST_ONE_CYCLE: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   AST_UNMAPPED: assert property (acc && !ac && !at |-> pslverr)
      else $error("unmapped access without error");
   AST_SILENT: assert property (q && !ctl[0] && !bs |-> !buzzer_out)
      else $error("tone while disabled");
   AST_CTRL_RB: assert property (rc |-> prdata[4:3] == ctl[4:3] && prdata[0] == ctl[0])
      else $error("control readback wrong");
   AST_WO_ZERO: assert property (rc |-> !prdata[2] && !prdata[6] && prdata[31:7] == 25'h0)
      else $error("write-only bits read nonzero");
   AST_BUSY: assert property (rc && bs && tc < BT |-> prdata[5])
      else $error("burst not busy");
   AST_STOP: assert property (rc && !bs |-> !prdata[5])
      else $error("busy after stop");
   AST_BURST_ENV: assert property (rc && bs && tc < BT |-> !prdata[1])
      else $error("envelope on during burst");
   AST_HIGH_BOUND: assert property (hc <= HM)
      else $error("high time too long");
   COV_TRIG: cover property (wc && pwdata[5]);
   COV_STOP: cover property (wc && pwdata[6]);
   COV_ERR: cover property (acc && pslverr);
endmodule // buzzer_checker
bind buzzer_tone_envelope_generator buzzer_checker #(.SUBSTEP_DIV(SUBSTEP_DIV),
   .BURST_SHORT_CYC(BURST_SHORT_CYC)) buzzer_checker_i (.sys_clk(sys_clk),
   .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .buzzer_out(buzzer_out));

// ### piezo_model.sv
// Purpose : Piezo load that times the tone it is driven with
// Assumes : Drive sampled on sys_clk
// Notes   : First period after a change may be partial
`timescale 1ns/1ps
module piezo_model
(
   input  wire        sys_clk,
   input  wire        reset_n,
   input  wire        drive,
   output reg  [15:0] hi_len,
   output reg  [15:0] per_len,
   output reg  [15:0] periods
);
   reg [15:0] hc;
   reg [15:0] pc;
   reg        last;
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         {hi_len, per_len, periods, hc, pc} <= 80'h0;
         last <= 1'b0;
      end
      else
      begin
         last <= drive;
         hc   <= drive ? hc + 16'h0001 : 16'h0000;
         pc   <= (drive && !last) ? 16'h0001 : pc + 16'h0001;
         if (drive && !last)
            {per_len, periods} <= {pc, periods + 16'h0001};
         if (!drive && last)
            hi_len <= hc;
      end
   end
endmodule // piezo_model

// ### buzzer_tone_envelope_generator_tb_top.sv
// Purpose : Self-checking bench for the buzzer tone generator
// Assumes : Shortened burst and envelope counts
// Notes   : Tone timing is measured by the piezo model
`timescale 1ns/1ps
`include "buzzer_regs.vh"
module buzzer_tone_envelope_generator_tb_top;
   localparam [17:0] AC = `ADDR_BURST_ENVELOPE_CONTROL;
   localparam [17:0] AT = `ADDR_TONE_DUTY_FREQUENCY;
   logic        sys_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h0;
   wire  [31:0] prdata;
   wire         pready, pslverr, buzzer_out;
   wire  [15:0] hi_len, per_len, periods;
   integer      errors = 0;
   integer      comparisons = 0;
   logic [31:0] r;
   logic        e;
   always #20 sys_clk = ~sys_clk;
   buzzer_tone_envelope_generator #(.SUBSTEP_DIV(9'h004), .BURST_LONG_CYC(25'hC8),
      .BURST_SHORT_CYC(25'h32), .ENV_LONG_CYC(25'h578), .ENV_SHORT_CYC(25'h2BC))
   buzzer_tone_envelope_generator_i (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .buzzer_out(buzzer_out));
   piezo_model piezo_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .drive(buzzer_out),
      .hi_len(hi_len), .per_len(per_len), .periods(periods));
   task end_sim;
      if (errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input string nm, input [31:0] s, input [31:0] x);
      comparisons = comparisons + 1;
      if (s !== x)
      begin
         errors = errors + 1;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask
   task apb(input w, input [17:0] a, input [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      // Wait is open-ended by intent; the watchdog ends a hang
      while (pready !== 1'b1)
         @(posedge sys_clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rchk(input [17:0] a, input [31:0] x, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, r, x);
   endtask
   task meas(input integer hx, input integer px);
      integer p0;
      p0 = periods;
      while (periods < p0 + 3)
         @(posedge sys_clk);
      chk("high", hi_len, hx);
      chk("period", per_len, px);
   endtask
   task t_reset;
      rchk(AC, 32'h0, "ctl");
      rchk(AT, 32'h0, "tone");
      chk("out", buzzer_out, 32'h0);
      apb(1'b0, 18'h00100, 32'h0);
      chk("err", e, 32'h1);
   endtask
   task t_tone;
      integer f, d, m;
      apb(1'b1, AC, 32'h01);
      for (f = 0; f < 16; f = f + 1)
      begin
         d = (f % 2) * 7;
         m = f > 7 ? 2 : 1;
         apb(1'b1, AT, d * 16 + f / 2);
         rchk(AT, d * 16 + f / 2, "tone");
         meas(((f % 8 > 3 ? 12 : 8) - d) * 4 * m, (16 + f / 2 % 4 * 4) * 4 * m);
      end
   endtask
   task t_burst;
      apb(1'b1, AC, 32'h00);
      apb(1'b1, AC, 32'h22);
      rchk(AC, 32'h20, "busy");
      repeat (60) @(posedge sys_clk);
      rchk(AC, 32'h00, "short");
      apb(1'b1, AC, 32'h30);
      repeat (100) @(posedge sys_clk);
      rchk(AC, 32'h30, "long");
      apb(1'b1, AC, 32'h50);
      rchk(AC, 32'h10, "stop");
   endtask
   task t_env;
      apb(1'b1, AT, 32'h0);
      apb(1'b1, AC, 32'h0B);
      repeat (1050) @(posedge sys_clk);
      meas(32, 64);
      apb(1'b1, AC, 32'h07);
      rchk(AC, 32'h03, "restart");
      repeat (5000) @(posedge sys_clk);
      meas(4, 64);
      apb(1'b1, AC, 32'h07);
      meas(32, 64);
      repeat (5000) @(posedge sys_clk);
      apb(1'b1, AC, 32'h01);
      meas(32, 64);
   endtask
   initial
   begin
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      t_reset;
      t_tone;
      t_burst;
      t_env;
      end_sim;
   end
   initial
   begin
      #2000000;
      errors = errors + 1;
      end_sim;
   end
endmodule // buzzer_tone_envelope_generator_tb_top
